// [motor_pwm_defs.svh]
`ifndef MOTOR_PWM_DEFS_SVH
`define MOTOR_PWM_DEFS_SVH

// Register byte offsets
`define OFS_CTRL      6'h00
`define OFS_COUNT     6'h04
`define OFS_PERIOD    6'h08
`define OFS_SECMP     6'h0C
`define OFS_DUTY1     6'h10
`define OFS_DUTY2     6'h14
`define OFS_DUTY3     6'h18
`define OFS_DT1       6'h1C
`define OFS_DT2       6'h20
`define OFS_OVD       6'h24
`define OFS_PCON1     6'h28
`define OFS_FLTA      6'h2C
`define OFS_FLTB      6'h30
`define OFS_OSCSEL    6'h34

// Control and count register fields
`define CTRL_EN_BIT   15
`define CTRL_OPS_HI   7
`define CTRL_OPS_LO   4
`define CTRL_CKPS_HI  3
`define CTRL_CKPS_LO  2
`define CTRL_MOD_HI   1
`define CTRL_MOD_LO   0
`define COUNT_DIR_BIT 15

// Oscillator select word fields
`define OSC_LOCK_BIT  6
`define OSC_RD_MASK   8'hC7

// Dead-time, pair mode and override enable fields
`define DT_A_HI       5
`define DT_A_LO       0
`define DT_B_HI       13
`define DT_B_LO       8
`define DT_METHOD_BIT 8
`define PCON1_PMOD_LO 8
`define OVD_EN_LO     8

// Reset values
`define RST_OVD       16'h3F00
`define RST_WORD16    16'h0000

// Prescaler terminal counts
`define PRESC_T1      6'h00
`define PRESC_T4      6'h03
`define PRESC_T16     6'h0F
`define PRESC_T64     6'h3F

`endif

// [motor_pwm_pkg.sv]
`default_nettype none
package motor_pwm_pkg;

  // Time base counting modes
  typedef enum logic [1:0] {
    MODE_FREE   = 2'h0,
    MODE_SINGLE = 2'h1,
    MODE_UPDOWN = 2'h2,
    MODE_DOUBLE = 2'h3
  } tb_mode_e;

  // Avalon-MM request from the master
  typedef struct packed {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } av_req_s;

endpackage
`default_nettype wire

// [motor_pwm_time_base.sv]
// Our own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "motor_pwm_defs.svh"

// What this block does
// - Lock bit blocks pair and fault writes
// - Three generators, each with duty register
// - Complementary pairs get dead time automatically
// - Method one: A before high, B before low
// - Method two: unit A or B per pair
// - Override bits force pins to levels
// - Special event trigger starts conversion
// - Control bits 1:0 select mode
// - Free-running counts up, wraps after match
// - Single event wraps, clears enable, halts
// - Up/down reverses at match, direction bit
// - Double mode events at zero and match
// - Fifteen-bit timer with pre- and postscaler
// - Prescale by 1, 4, 16 or 64
// - Count or control write clears prescaler
// - Period match and zero detect signals
// - Count bit 15 shows count direction
// - Disabling stops count, keeps value
// - Postscale events 1:1 to 1:16
// - Count or control write clears postscaler
// - Period double-buffered, loaded by mode
// - Postscaler ignored in single, double modes
module motor_pwm_time_base #(
  parameter int PAIRS = 3
) (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  // Avalon-MM register slave
  input  wire motor_pwm_pkg::av_req_s  bus_req,
  output logic [31:0]                  readdata,
  output logic                         waitrequest,
  // Device configuration word pins
  input  wire logic [7:0]              osc_config_pins,
  // Time base events
  output logic                         period_match,
  output logic                         zero_detect,
  output logic                         pwm_interrupt_flag,
  output logic                         adc_trigger,
  // Power stage drive
  output logic [PAIRS-1:0]             pwm_high,
  output logic [PAIRS-1:0]             pwm_low
);

  // Merge a 16-bit register with byte enables
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    merge16 = {(be[1] ? wd[15:8] : old[15:8]), (be[0] ? wd[7:0] : old[7:0])};
  endfunction

  // Prescaler terminal count from select code
  function automatic logic [5:0] presc_term(input logic [1:0] sel);
    case (sel)
      2'h0:    presc_term = `PRESC_T1;
      2'h1:    presc_term = `PRESC_T4;
      2'h2:    presc_term = `PRESC_T16;
      default: presc_term = `PRESC_T64;
    endcase
  endfunction

  // Configuration word synchroniser
  logic [7:0]  osc_s1, osc_s2, osc_s3;        // Three-stage pin capture
  logic [7:0]  oscillator_select_config;      // Accepted configuration word
  logic [7:0]  next_oscillator_select_config; // Next accepted word
  logic        config_write_lock;             // Write lock bit

  // Software registers
  logic [7:0]  ctrl_lo, next_ctrl_lo;                 // Mode, prescale, postscale
  logic [14:0] period_buf, next_period_buf;           // Software period
  logic [14:0] secmp, next_secmp;                     // Special event compare
  logic [14:0] duty [PAIRS], next_duty [PAIRS];       // Duty values
  logic [15:0] dead_time_control_one, next_dt1;       // Dead times A and B
  logic [15:0] dead_time_control_two, next_dt2;       // Method and unit select
  logic [15:0] override_control, next_ovd;            // Override enables and levels
  logic [15:0] pair_control_one, next_pcon1;          // Pair mode bits
  logic [15:0] fault_a_control, next_flta;            // Fault A control
  logic [15:0] fault_b_control, next_fltb;            // Fault B control
  logic        read_valid, next_read_valid;           // Read answer ready
  logic [31:0] next_readdata;                         // Read answer

  // Time base state
  logic        time_base_enable, next_enable;         // Enable bit
  logic [14:0] count, next_count;                     // Count value field
  logic        count_direction_status, next_dir;      // Down when set
  logic [14:0] period_act, next_period_act;           // Active period
  logic [5:0]  presc, next_presc;                     // Prescaler counter
  logic [3:0]  post, next_post;                       // Postscaler counter
  logic        next_irq, next_trig;                   // Event pulses

  // Output stage state
  logic [PAIRS-1:0] side, next_side;                  // Commanded side per pair
  logic [5:0]       dt_cnt [PAIRS];                   // Dead-time counters
  logic [5:0]       next_dt_cnt [PAIRS];
  logic [PAIRS-1:0] next_high, next_low;

  // Decoded bus strobes, tick, match and zero conditions, and mode
  logic        wr, wr_ctrl, wr_count;
  logic        tick, match_now, zero_now;
  motor_pwm_pkg::tb_mode_e mode;

  assign mode      = motor_pwm_pkg::tb_mode_e'(ctrl_lo[`CTRL_MOD_HI:`CTRL_MOD_LO]);
  assign wr        = bus_req.write;
  assign wr_ctrl   = wr && (bus_req.address == `OFS_CTRL);
  assign wr_count  = wr && (bus_req.address == `OFS_COUNT);
  assign config_write_lock = oscillator_select_config[`OSC_LOCK_BIT];

  // Reads wait one cycle, writes complete at once
  assign waitrequest = bus_req.read && !read_valid;

  // Period match and zero detect from the count field
  assign match_now    = (count == period_act);
  assign zero_now     = (count == 15'h0000);
  assign period_match = match_now;
  assign zero_detect  = zero_now;

  // Accept the configuration word once two late stages agree
  always_comb begin
    next_oscillator_select_config = oscillator_select_config;
    if (osc_s2 == osc_s3) begin
      next_oscillator_select_config = osc_s3;
    end
  end

  // Synchroniser registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      osc_s1                   <= 8'h00;
      osc_s2                   <= 8'h00;
      osc_s3                   <= 8'h00;
      oscillator_select_config <= 8'h00;
    end else begin
      osc_s1                   <= osc_config_pins;
      osc_s2                   <= osc_s1;
      osc_s3                   <= osc_s2;
      oscillator_select_config <= next_oscillator_select_config;
    end
  end

  // Register writes and read decode
  always_comb begin
    next_ctrl_lo    = ctrl_lo;
    next_period_buf = period_buf;
    next_secmp      = secmp;
    next_duty       = duty;
    next_dt1        = dead_time_control_one;
    next_dt2        = dead_time_control_two;
    next_ovd        = override_control;
    next_pcon1      = pair_control_one;
    next_flta       = fault_a_control;
    next_fltb       = fault_b_control;
    next_read_valid = bus_req.read && !read_valid;
    next_readdata   = readdata;
    if (wr) begin
      case (bus_req.address)
        `OFS_CTRL:   next_ctrl_lo = bus_req.byteenable[0] ? bus_req.writedata[7:0] : ctrl_lo;
        `OFS_PERIOD: next_period_buf = 15'(merge16({1'b0, period_buf}, bus_req.writedata, bus_req.byteenable));
        `OFS_SECMP:  next_secmp = 15'(merge16({1'b0, secmp}, bus_req.writedata, bus_req.byteenable));
        `OFS_DUTY1:  next_duty[0] = 15'(merge16({1'b0, duty[0]}, bus_req.writedata, bus_req.byteenable));
        `OFS_DUTY2:  next_duty[1] = 15'(merge16({1'b0, duty[1]}, bus_req.writedata, bus_req.byteenable));
        `OFS_DUTY3:  next_duty[2] = 15'(merge16({1'b0, duty[2]}, bus_req.writedata, bus_req.byteenable));
        `OFS_DT1:    next_dt1 = merge16(dead_time_control_one, bus_req.writedata, bus_req.byteenable);
        `OFS_DT2:    next_dt2 = merge16(dead_time_control_two, bus_req.writedata, bus_req.byteenable);
        `OFS_OVD:    next_ovd = merge16(override_control, bus_req.writedata, bus_req.byteenable);
        // Locked registers ignore writes
        `OFS_PCON1: begin
          if (!config_write_lock) next_pcon1 = merge16(pair_control_one, bus_req.writedata, bus_req.byteenable);
        end
        `OFS_FLTA: begin
          if (!config_write_lock) next_flta = merge16(fault_a_control, bus_req.writedata, bus_req.byteenable);
        end
        `OFS_FLTB: begin
          if (!config_write_lock) next_fltb = merge16(fault_b_control, bus_req.writedata, bus_req.byteenable);
        end
        default: next_ctrl_lo = ctrl_lo;
      endcase
    end
    // Capture read answer on the first read cycle
    if (bus_req.read && !read_valid) begin
      case (bus_req.address)
        `OFS_CTRL:   next_readdata = {16'h0000, time_base_enable, 7'h00, ctrl_lo};
        `OFS_COUNT:  next_readdata = {16'h0000, count_direction_status, count};
        `OFS_PERIOD: next_readdata = {17'h00000, period_buf};
        `OFS_SECMP:  next_readdata = {17'h00000, secmp};
        `OFS_DUTY1:  next_readdata = {17'h00000, duty[0]};
        `OFS_DUTY2:  next_readdata = {17'h00000, duty[1]};
        `OFS_DUTY3:  next_readdata = {17'h00000, duty[2]};
        `OFS_DT1:    next_readdata = {16'h0000, dead_time_control_one};
        `OFS_DT2:    next_readdata = {16'h0000, dead_time_control_two};
        `OFS_OVD:    next_readdata = {16'h0000, override_control};
        `OFS_PCON1:  next_readdata = {16'h0000, pair_control_one};
        `OFS_FLTA:   next_readdata = {16'h0000, fault_a_control};
        `OFS_FLTB:   next_readdata = {16'h0000, fault_b_control};
        `OFS_OSCSEL: next_readdata = {24'h000000, oscillator_select_config & `OSC_RD_MASK};
        default:     next_readdata = 32'h00000000;
      endcase
    end
  end

  // Register file
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_lo               <= 8'h00;
      period_buf            <= 15'h0000;
      secmp                 <= 15'h0000;
      duty                  <= '{default: 15'h0000};
      dead_time_control_one <= `RST_WORD16;
      dead_time_control_two <= `RST_WORD16;
      override_control      <= `RST_OVD;
      pair_control_one      <= `RST_WORD16;
      fault_a_control       <= `RST_WORD16;
      fault_b_control       <= `RST_WORD16;
      read_valid            <= 1'b0;
      readdata              <= 32'h00000000;
    end else begin
      ctrl_lo               <= next_ctrl_lo;
      period_buf            <= next_period_buf;
      secmp                 <= next_secmp;
      duty                  <= next_duty;
      dead_time_control_one <= next_dt1;
      dead_time_control_two <= next_dt2;
      override_control      <= next_ovd;
      pair_control_one      <= next_pcon1;
      fault_a_control       <= next_flta;
      fault_b_control       <= next_fltb;
      read_valid            <= next_read_valid;
      readdata              <= next_readdata;
    end
  end

  // Prescaled tick while enabled
  assign tick = time_base_enable && (presc == presc_term(ctrl_lo[`CTRL_CKPS_HI:`CTRL_CKPS_LO]));

  // Time base counter, period buffer, pre- and postscaler
  always_comb begin
    logic evt_scaled;
    logic evt_direct;
    evt_scaled      = 1'b0;
    evt_direct      = 1'b0;
    next_enable     = time_base_enable;
    next_count      = count;
    next_dir        = count_direction_status;
    next_period_act = period_act;
    next_post       = post;
    next_presc      = time_base_enable ? (tick ? 6'h00 : 6'(presc + 6'h01)) : 6'h00;
    // Disabled time base keeps count and tracks the buffer
    if (!time_base_enable) begin
      next_period_act = period_buf;
    end
    if (tick) begin
      case (mode)
        motor_pwm_pkg::MODE_FREE, motor_pwm_pkg::MODE_SINGLE: begin
          next_dir = 1'b0;
          if (match_now) begin
            next_count      = 15'h0000;
            next_period_act = period_buf;
            evt_scaled      = (mode == motor_pwm_pkg::MODE_FREE);
            evt_direct      = (mode == motor_pwm_pkg::MODE_SINGLE);
            if (mode == motor_pwm_pkg::MODE_SINGLE) next_enable = 1'b0;
          end else begin
            next_count = 15'(count + 15'h0001);
          end
        end
        default: begin
          // Up/down counting, both variants
          if (!count_direction_status) begin
            if (match_now && !zero_now) begin
              next_dir   = 1'b1;
              next_count = 15'(count - 15'h0001);
              evt_direct = (mode == motor_pwm_pkg::MODE_DOUBLE);
            end else begin
              next_count = match_now ? count : 15'(count + 15'h0001);
            end
            if (zero_now) begin
              next_period_act = period_buf;
              evt_scaled      = (mode == motor_pwm_pkg::MODE_UPDOWN);
              evt_direct      = (mode == motor_pwm_pkg::MODE_DOUBLE);
            end
          end else if (zero_now) begin
            next_dir        = 1'b0;
            next_count      = 15'h0001;
            next_period_act = period_buf;
            evt_scaled      = (mode == motor_pwm_pkg::MODE_UPDOWN);
            evt_direct      = (mode == motor_pwm_pkg::MODE_DOUBLE);
          end else begin
            next_count = 15'(count - 15'h0001);
          end
        end
      endcase
    end
    // Postscaler divides free-running and up/down events
    next_irq = evt_direct;
    if (evt_scaled) begin
      if (post == ctrl_lo[`CTRL_OPS_HI:`CTRL_OPS_LO]) begin
        next_post = 4'h0;
        next_irq  = 1'b1;
      end else begin
        next_post = 4'(post + 4'h1);
      end
    end
    // Software writes override hardware updates
    if (wr_count) begin
      next_count = 15'(merge16({1'b0, count}, bus_req.writedata, bus_req.byteenable));
    end
    if (wr_ctrl && bus_req.byteenable[1]) begin
      next_enable = bus_req.writedata[`CTRL_EN_BIT];
    end
    if (wr_ctrl || wr_count) begin
      next_presc = 6'h00;
      next_post  = 4'h0;
    end
    next_trig = tick && (next_count == secmp);
  end

  // Time base registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      time_base_enable       <= 1'b0;
      count                  <= 15'h0000;
      count_direction_status <= 1'b0;
      period_act             <= 15'h0000;
      presc                  <= 6'h00;
      post                   <= 4'h0;
      pwm_interrupt_flag     <= 1'b0;
      adc_trigger            <= 1'b0;
    end else begin
      time_base_enable       <= next_enable;
      count                  <= next_count;
      count_direction_status <= next_dir;
      period_act             <= next_period_act;
      presc                  <= next_presc;
      post                   <= next_post;
      pwm_interrupt_flag     <= next_irq;
      adc_trigger            <= next_trig;
    end
  end

  // Duty compare, dead time and override per pair
  always_comb begin
    logic       raw;
    logic       indep;
    logic [5:0] dt_val;
    raw    = 1'b0;
    indep  = 1'b0;
    dt_val = 6'h00;
    for (int i = 0; i < PAIRS; i++) begin
      raw = (count < duty[i]) && !(mode == motor_pwm_pkg::MODE_SINGLE && !time_base_enable);
      indep = pair_control_one[`PCON1_PMOD_LO + i];
      // Choose dead time by method
      if (dead_time_control_two[`DT_METHOD_BIT]) begin
        dt_val = dead_time_control_two[i] ? dead_time_control_one[`DT_B_HI:`DT_B_LO]
                                          : dead_time_control_one[`DT_A_HI:`DT_A_LO];
      end else begin
        dt_val = raw ? dead_time_control_one[`DT_A_HI:`DT_A_LO]
                     : dead_time_control_one[`DT_B_HI:`DT_B_LO];
      end
      next_side[i]   = raw;
      next_dt_cnt[i] = 6'h00;
      if (!indep && raw != side[i]) begin
        next_dt_cnt[i] = dt_val;
      end else if (dt_cnt[i] != 6'h00) begin
        next_dt_cnt[i] = 6'(dt_cnt[i] - 6'h01);
      end
      // Both off during dead time in complementary mode
      if (indep) begin
        next_high[i] = raw;
        next_low[i]  = raw;
      end else begin
        next_high[i] = (next_dt_cnt[i] == 6'h00) && raw;
        next_low[i]  = (next_dt_cnt[i] == 6'h00) && !raw;
      end
      // Override forces chosen levels
      if (!override_control[`OVD_EN_LO + 2 * i]) next_high[i] = override_control[2 * i];
      if (!override_control[`OVD_EN_LO + 2 * i + 1]) next_low[i] = override_control[2 * i + 1];
    end
  end

  // Output stage registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      side     <= '0;
      dt_cnt   <= '{default: 6'h00};
      pwm_high <= '0;
      pwm_low  <= '0;
    end else begin
      side     <= next_side;
      dt_cnt   <= next_dt_cnt;
      pwm_high <= next_high;
      pwm_low  <= next_low;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_single_match;
    tick && mode == motor_pwm_pkg::MODE_SINGLE && match_now && !wr;
  endsequence

  sequence s_single_halt;
    !time_base_enable && count == 15'h0000 ##1 ($stable(count) || $past(wr_count));
  endsequence

  property p_lock_blocks;
    wr && config_write_lock && bus_req.address == `OFS_PCON1 |=> $stable(pair_control_one);
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("locked register changed");

  property p_single_stop;
    s_single_match |=> s_single_halt;
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("single event did not halt");

  property p_free_wrap;
    tick && mode == motor_pwm_pkg::MODE_FREE && match_now && !wr |=> count == 15'h0000 && time_base_enable;
  endproperty
  a_free_wrap: assert property (p_free_wrap) else $error("free-running count did not wrap");

  property p_turn_down;
    tick && mode[1] && !count_direction_status && match_now && !zero_now && !wr |=> count_direction_status;
  endproperty
  a_turn_down: assert property (p_turn_down) else $error("direction not set at period match");

  property p_double_irq;
    tick && mode == motor_pwm_pkg::MODE_DOUBLE && (zero_now || match_now) && period_act > 15'h0001
      |=> pwm_interrupt_flag ##1 !pwm_interrupt_flag;
  endproperty
  a_double_irq: assert property (p_double_irq) else $error("double update event missing");

  property p_presc_clear;
    wr_ctrl |=> presc == 6'h00 && post == 4'h0;
  endproperty
  a_presc_clear: assert property (p_presc_clear) else $error("scalers not cleared on control write");

  property p_hold_off;
    !time_base_enable && !wr_count |=> $stable(count);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("count moved while disabled");

  property p_trigger;
    adc_trigger |-> count == $past(secmp) && $past(tick);
  endproperty
  a_trigger: assert property (p_trigger) else $error("trigger without compare match");

  property p_no_shoot;
    !pair_control_one[`PCON1_PMOD_LO] && override_control[`OVD_EN_LO +: 2] == 2'h3 |-> !(pwm_high[0] && pwm_low[0]);
  endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("complementary pair both on");

  property p_read_answer;
    bus_req.read && waitrequest |=> !waitrequest;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered in one cycle");

endmodule
`default_nettype wire

// [motor_pwm_inverter.sv]
`timescale 1ns/1ps
`default_nettype none
// Inverter stage model: one leg per pair, flags a leg with both switches on
module inverter_stage #(
  parameter int PAIRS = 3
) (
  // Gate drives from the block
  input  wire logic [PAIRS-1:0] gate_high,
  input  wire logic [PAIRS-1:0] gate_low,
  // Leg short indication
  output logic                  shoot_through
);
  // Both switches of one leg on shorts the supply
  assign shoot_through = |(gate_high & gate_low);
endmodule
`default_nettype wire

// [motor_pwm_time_base_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "motor_pwm_defs.svh"
module motor_pwm_time_base_tb;
  logic                   clk_sys = 0;
  logic                   rst_n = 0;
  motor_pwm_pkg::av_req_s bus_req = '0;
  logic [31:0]            readdata;
  logic                   waitrequest, period_match, zero_detect, irq, adc_trigger, short_leg;
  logic [2:0]             pwm_high, pwm_low;
  logic [7:0]             pins = 8'h00;
  logic [15:0]            v;
  logic [31:0]            seed = 32'hEF76;
  logic [31:0]            exp_q[$];
  int                     num_errors = 0, n_compared = 0, n;
  // Period, control word and expected event spacing in cycles
  localparam logic [31:0] CFG [8] = '{32'h0002_8000, 32'h0002_8004, 32'h0001_8008, 32'h0001_800C,
                                      32'h0002_8030, 32'h0001_80F0, 32'h0003_8002, 32'h0003_8033};
  localparam int          GAP [8] = '{3, 12, 32, 128, 12, 32, 6, 3};
  always #2.5 clk_sys = ~clk_sys;
  motor_pwm_time_base dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .readdata(readdata),
    .waitrequest(waitrequest), .osc_config_pins(pins), .period_match(period_match), .zero_detect(zero_detect),
    .pwm_interrupt_flag(irq), .adc_trigger(adc_trigger), .pwm_high(pwm_high), .pwm_low(pwm_low));
  inverter_stage load_u (.gate_high(pwm_high), .gate_low(pwm_low), .shoot_through(short_leg));
  // Xorshift step
  function automatic logic [31:0] xs(logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Compare and count
  task automatic cmp(logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // Verdict and end of run
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(logic w, logic [5:0] a, logic [15:0] d);
    @(posedge clk_sys);
    bus_req <= '{read: !w, write: w, address: a, writedata: {16'h0000, d}, byteenable: 4'h3};
    n = 0;
    do begin @(posedge clk_sys); n++; end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin num_errors++; stop_test(); end
    bus_req <= '0;
  endtask
  // Read with expectation noted for the monitor
  task automatic rd(logic [5:0] a, logic [15:0] e);
    exp_q.push_back({16'h0000, e});
    bus(1'b0, a, 16'h0000);
  endtask
  // Stop, load period and count, then write control
  task automatic start(logic [15:0] p, logic [15:0] c, logic [15:0] ctl);
    bus(1'b1, `OFS_CTRL, 16'h0000);
    bus(1'b1, `OFS_PERIOD, p);
    bus(1'b1, `OFS_COUNT, c);
    bus(1'b1, `OFS_CTRL, ctl);
  endtask
  // Wait for an interrupt or trigger pulse, n holds cycles waited
  task automatic wait_ev(logic sel);
    n = 0;
    do begin @(negedge clk_sys); n++; end while ((sel ? adc_trigger : irq) !== 1'b1 && n < 2000);
    if (n >= 2000) begin num_errors++; stop_test(); end
  endtask
  // Monitor: read data against oldest note, and leg shorts
  always @(posedge clk_sys) begin
    if (bus_req.read && waitrequest === 1'b0 && exp_q.size() > 0) cmp(exp_q.pop_front(), readdata);
    if (short_leg === 1'b1) cmp(32'h0, 32'h1);
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(`OFS_CTRL, `RST_WORD16);
    rd(`OFS_OVD, `RST_OVD);
    $display("test reset done");
    // Unlocked then locked fault register writes, random pins
    for (int i = 0; i < 2; i++) begin
      seed = xs(seed);
      pins <= {seed[7], i[0], seed[5:0]};
      repeat (6) @(posedge clk_sys);
      rd(`OFS_OSCSEL, {8'h00, pins & `OSC_RD_MASK});
      bus(1'b1, `OFS_FLTA, {8'h00, seed[15:8]});
      if (i == 0) v = {8'h00, seed[15:8]};
      rd(`OFS_FLTA, v);
    end
    $display("test lock done");
    for (int i = 0; i < 8; i++) begin
      start(CFG[i][31:16], 16'h0000, CFG[i][15:0]);
      repeat (3) wait_ev(1'b0);
      cmp(32'(GAP[i]), 32'(n));
    end
    $display("test modes done");
    start(16'h0002, 16'h0000, 16'h8001);
    wait_ev(1'b0);
    rd(`OFS_CTRL, 16'h0001);
    rd(`OFS_COUNT, 16'h0000);
    @(negedge clk_sys);
    cmp(32'h1, {30'h0, period_match, zero_detect});
    start(16'h0005, 16'h0005, 16'h0000);
    repeat (8) @(negedge clk_sys);
    cmp(32'h2, {30'h0, period_match, zero_detect});
    rd(`OFS_COUNT, 16'h0005);
    // Dead time A before the high side turns on, then a forced level
    bus(1'b1, `OFS_DT1, 16'h0004);
    bus(1'b1, `OFS_DUTY1, 16'h0006);
    repeat (2) @(negedge clk_sys);
    cmp(32'h0, {30'h0, pwm_high[0], pwm_low[0]});
    repeat (8) @(negedge clk_sys);
    cmp(32'h2, {30'h0, pwm_high[0], pwm_low[0]});
    bus(1'b1, `OFS_OVD, 16'h3C02);
    repeat (2) @(negedge clk_sys);
    cmp(32'h1, {30'h0, pwm_high[0], pwm_low[0]});
    bus(1'b1, `OFS_OVD, `RST_OVD);
    bus(1'b1, `OFS_SECMP, 16'h0001);
    start(16'h0002, 16'h0000, 16'h8000);
    repeat (2) wait_ev(1'b1);
    cmp(32'h3, 32'(n));
    $display("test single hold trigger done");
    stop_test();
  end
endmodule
`default_nettype wire
